// ---- pkg/lmx_pkg.sv ----
// Constants and types shared by the LED matrix control register block.
package lmx_pkg;
   // Register offsets on the serial register port.
   localparam logic [7:0] REG_RESET = 8'h01;
   localparam logic [7:0] REG_POWER = 8'h02;
   localparam logic [7:0] REG_OPTION = 8'h04;
   localparam logic [7:0] REG_MATRIX = 8'h05;
   localparam logic [7:0] REG_PWM_FIRST = 8'h06;
   localparam logic [7:0] REG_PWM_LAST = 8'h10;
   localparam logic [7:0] REG_MLD_FIRST = 8'h11;
   localparam logic [7:0] REG_MLD_LAST = 8'h1b;
   localparam logic [7:0] REG_GROUP = 8'h2a;
   localparam logic [7:0] REG_THRESHOLD = 8'h2b;
   // Number of per-LED enable registers in each bank.
   localparam int BANK_REGS = 11;
   // Reset values.
   localparam logic [7:0] RST_POWER = 8'h00;
   localparam logic [7:0] RST_OPTION = 8'h00;
   localparam logic [7:0] RST_MATRIX = 8'h1e;
   localparam logic [7:0] RST_BANK = 8'h00;
   localparam logic [7:0] RST_GROUP = 8'h00;
   localparam logic [7:0] RST_THRESHOLD = 8'h00;
   // Field positions.
   localparam int BIT_SOFT_RESET = 0;
   localparam int BIT_MEM_CLEAR = 1;
   localparam int BIT_OSC_EN = 0;
   localparam int BIT_EXT_CLK = 0;
   localparam int BIT_CLK_OUT = 1;
   localparam int BIT_MELODY = 2;
   localparam int BIT_GHOST = 3;
   localparam int BIT_MTX_EN = 0;
   localparam int BIT_MAX_CURRENT_CODE_LO = 1;
   localparam int BIT_MTX_RSVD = 4;
   localparam int GROUP_BITS = 4;
   // Row index of the first lit row in a group sequence (row I).
   localparam logic [3:0] ROW_FIRST = 4'h8;
   // Base of the 7-bit slave address; value is arbitrary, low two bits come from straps.
   localparam logic [4:0] SLAVE_ADDR_BASE = 5'h0a;

   // Serial engine states.
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_AACK = 3'b010,
      ST_PTR = 3'b011,
      ST_PACK = 3'b100,
      ST_WDAT = 3'b101,
      ST_RDAT = 3'b110,
      ST_MACK = 3'b111
   } lmx_state_type;

   // Clock source selection after priority resolution.
   typedef struct packed {
      logic ext_clock;
      logic clock_out;
      logic melody;
   } lmx_clock_mode_type;
endpackage : lmx_pkg

// ---- logic/lmx_control_regs.sv ----
// Control register bank of the 9x9 LED matrix driver behind its serial register port.
//
// How it works
// - Memory clear bit erases duty and intensity.
// - Soft reset bit resets logic; zero releases.
// - Reset register bits clear themselves.
// - Power bit 0 switches oscillator, default off.
// - Oscillator runs whenever matrix enable set.
// - Option bit 3 enables ghost suppression.
// - Option bit 2 activates external melody mode.
// - Option bit 1 routes internal clock out.
// - Option bit 0 selects external clock.
// - Priority: external clock, clock out, melody.
// - Matrix bits 3-1 max current, reset 1Eh.
// - Matrix bit 0 switches matrix drive.
// - Further PWM registers share that layout.
// - First melody register maps A8..A1 bits.
// - Further melody registers share that layout.
// - Group bits sequence columns rows I to A.
// - Unimplemented bits read zero, except matrix bit 4, which reads one; writes ignored.
// - All-zero threshold means automatic detection.
`timescale 1ns/1ps
module lmx_control_regs
   import lmx_pkg::*;
(
   input wire logic clk,
   input wire logic soft_reset_bit,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic [1:0] addr_sel,
   input wire logic melody_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic soft_reset_pulse,
   output logic memory_clear_pulse,
   output logic osc_run,
   output logic ghost_suppress_enable,
   output lmx_clock_mode_type clock_mode,
   output logic [2:0] max_current_code,
   output logic matrix_enable,
   output logic [8*BANK_REGS-1:0] led_pwm_select,
   output logic [8*BANK_REGS-1:0] led_melody_select,
   output logic [GROUP_BITS-1:0] column_group_melody_bit,
   output logic [8:0] group_row_lit,
   output logic [7:0] threshold_select,
   output logic auto_threshold
);
   // Two-stage synchronisers for the scl, sda, addr_sel and melody inputs, plus one history stage on all but addr_sel.
   logic scl_s1, scl_s2, scl_q;
   logic sda_s1, sda_s2, sda_q;
   logic [1:0] asel_s1, asel_s2;
   logic mel_s1, mel_s2, mel_q;
   // Serial engine state.
   lmx_state_type state;
   logic [7:0] shift; // Receive shift register.
   logic [7:0] tx; // Transmit shift register.
   logic [2:0] bit_cnt; // Bits of the current byte seen so far.
   logic byte_full; // Eighth bit taken, waiting for the falling edge.
   logic rw_bit; // High for a read transfer.
   logic [7:0] ptr; // Register pointer, auto-increments.
   logic addr_hit_q; // Address match, held until the falling edge that acts on it.
   // Register contents.
   logic osc_en;
   logic [7:0] option;
   logic [3:0] matrix;
   logic [7:0] pwm_bank [BANK_REGS];
   logic [7:0] mld_bank [BANK_REGS];
   logic [GROUP_BITS-1:0] group;
   logic [7:0] threshold;
   logic [3:0] row_step; // Current lit row of the group sequence.

   // Edge and bus condition decode on the synchronised pins.
   wire scl_rise = scl_s2 & ~scl_q;
   wire scl_fall = ~scl_s2 & scl_q;
   wire bus_start = scl_s2 & scl_q & sda_q & ~sda_s2;
   wire bus_stop = scl_s2 & scl_q & ~sda_q & sda_s2;
   wire [7:0] next_shift = {shift[6:0], sda_s2};
   wire last_bit = scl_rise & (bit_cnt == 3'h7);
   wire addr_hit = (next_shift[7:1] == {SLAVE_ADDR_BASE, asel_s2});
   // A data byte is written on the rise of its eighth bit.
   wire wr_stb = (state == ST_WDAT) & last_bit;
   wire [7:0] wr_data = next_shift;
   // Soft reset returns the registers to defaults; the serial engine keeps running under the command pulse, not under soft_reset_bit.
   wire cfg_clr = soft_reset_bit | soft_reset_pulse;
   wire [7:0] pwm_idx = ptr - REG_PWM_FIRST;
   wire [7:0] mld_idx = ptr - REG_MLD_FIRST;
   wire pwm_hit = (ptr >= REG_PWM_FIRST) && (ptr <= REG_PWM_LAST);
   wire mld_hit = (ptr >= REG_MLD_FIRST) && (ptr <= REG_MLD_LAST);
   wire [7:0] rd_data =
      (ptr == REG_POWER) ? {7'h00, osc_en} :
      (ptr == REG_OPTION) ? {4'h0, option[3:0]} :
      (ptr == REG_MATRIX) ? {3'h0, RST_MATRIX[BIT_MTX_RSVD], matrix} :
      pwm_hit ? pwm_bank[pwm_idx[3:0]] :
      mld_hit ? mld_bank[mld_idx[3:0]] :
      (ptr == REG_GROUP) ? {4'h0, group} :
      (ptr == REG_THRESHOLD) ? threshold : 8'h00;
   wire ext_sel = option[BIT_EXT_CLK];
   wire out_sel = option[BIT_CLK_OUT] & ~ext_sel;
   wire mel_sel = option[BIT_MELODY] & ~option[BIT_CLK_OUT] & ~ext_sel;
   wire mel_edge = mel_s2 & ~mel_q;

   // Synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk) begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
      asel_s1 <= addr_sel;
      asel_s2 <= asel_s1;
      mel_s1 <= melody_in;
      mel_s2 <= mel_s1;
      mel_q <= mel_s2;
   end

   // Serial slave engine: samples on clock rise, changes the data line on clock fall.
   always_ff @(posedge clk) begin
      if (soft_reset_bit) begin
         state <= ST_IDLE;
         shift <= 8'h00;
         tx <= 8'h00;
         bit_cnt <= 3'h0;
         byte_full <= 1'b0;
         rw_bit <= 1'b0;
         ptr <= 8'h00;
         sda_oe_n <= 1'b1;
      end else if (bus_start) begin
         // A repeated start keeps the pointer so a read can follow a pointer write.
         state <= ST_ADDR;
         bit_cnt <= 3'h0;
         byte_full <= 1'b0;
         sda_oe_n <= 1'b1;
      end else if (bus_stop) begin
         state <= ST_IDLE;
         sda_oe_n <= 1'b1;
      end else begin
         case (state)
            ST_ADDR, ST_PTR, ST_WDAT: begin
               if (scl_rise) begin
                  shift <= next_shift;
                  bit_cnt <= bit_cnt + 3'h1;
                  byte_full <= (bit_cnt == 3'h7);
               end
               if (wr_stb) begin
                  ptr <= ptr + 8'h01;
               end
               if (scl_fall && byte_full) begin
                  byte_full <= 1'b0;
                  if (state == ST_ADDR) begin
                     rw_bit <= shift[0];
                     state <= addr_hit_q ? ST_AACK : ST_IDLE;
                     sda_oe_n <= ~addr_hit_q;
                  end else begin
                     if (state == ST_PTR) begin
                        ptr <= shift;
                     end
                     state <= ST_PACK;
                     sda_oe_n <= 1'b0;
                  end
               end
            end
            ST_AACK, ST_MACK: begin
               // A not-acknowledge from the master ends a read.
               if (state == ST_MACK && scl_rise && sda_s2) begin
                  state <= ST_IDLE;
               end else if (scl_fall) begin
                  bit_cnt <= 3'h0;
                  if (rw_bit) begin
                     state <= ST_RDAT;
                     tx <= rd_data;
                     sda_oe_n <= rd_data[7];
                     ptr <= ptr + 8'h01;
                  end else begin
                     state <= ST_PTR;
                     sda_oe_n <= 1'b1;
                  end
               end
            end
            ST_PACK: begin
               if (scl_fall) begin
                  state <= ST_WDAT;
                  bit_cnt <= 3'h0;
                  sda_oe_n <= 1'b1;
               end
            end
            ST_RDAT: begin
               if (scl_rise) begin
                  bit_cnt <= bit_cnt + 3'h1;
                  byte_full <= (bit_cnt == 3'h7);
               end
               if (scl_fall) begin
                  if (byte_full) begin
                     byte_full <= 1'b0;
                     state <= ST_MACK;
                     sda_oe_n <= 1'b1;
                  end else begin
                     tx <= {tx[6:0], 1'b0};
                     sda_oe_n <= tx[6];
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               sda_oe_n <= 1'b1;
            end
         endcase
      end
   end

   // Address match is held from the eighth rise until the falling edge that acts on it.
   always_ff @(posedge clk) begin
      if (soft_reset_bit) begin
         addr_hit_q <= 1'b0;
      end else if (state == ST_ADDR && last_bit) begin
         addr_hit_q <= addr_hit;
      end
   end

   // The data line is open drain and only ever pulled low.
   always_ff @(posedge clk) begin
      sda_out <= 1'b0;
   end

   // Command pulses from the write-only reset register; they never read back.
   always_ff @(posedge clk) begin
      if (soft_reset_bit) begin
         soft_reset_pulse <= 1'b0;
         memory_clear_pulse <= 1'b0;
      end else begin
         memory_clear_pulse <= wr_stb && ptr == REG_RESET && wr_data[BIT_MEM_CLEAR];
         soft_reset_pulse <= wr_stb && ptr == REG_RESET && wr_data[BIT_SOFT_RESET];
      end
   end

   // Scalar control registers; only implemented bits are stored.
   always_ff @(posedge clk) begin
      if (cfg_clr) begin
         osc_en <= RST_POWER[BIT_OSC_EN];
         option <= RST_OPTION;
         matrix <= RST_MATRIX[3:0];
         group <= RST_GROUP[GROUP_BITS-1:0];
         threshold <= RST_THRESHOLD;
      end else if (wr_stb) begin
         if (ptr == REG_POWER) begin
            osc_en <= wr_data[BIT_OSC_EN];
         end else if (ptr == REG_OPTION) begin
            option <= {4'h0, wr_data[3:0]};
         end else if (ptr == REG_MATRIX) begin
            matrix <= wr_data[3:0];
         end else if (ptr == REG_GROUP) begin
            group <= wr_data[GROUP_BITS-1:0];
         end else if (ptr == REG_THRESHOLD) begin
            threshold <= wr_data;
         end
      end
   end

   // Per-LED PWM and melody enable banks, one register per entry, LED n on bit n-1.
   for (genvar i = 0; i < BANK_REGS; i++) begin : g_bank
      always_ff @(posedge clk) begin
         if (cfg_clr) begin
            pwm_bank[i] <= RST_BANK;
            mld_bank[i] <= RST_BANK;
            led_pwm_select[8*i +: 8] <= RST_BANK;
            led_melody_select[8*i +: 8] <= RST_BANK;
         end else begin
            if (wr_stb && ptr == REG_PWM_FIRST + 8'(i)) begin
               pwm_bank[i] <= wr_data;
            end
            if (wr_stb && ptr == REG_MLD_FIRST + 8'(i)) begin
               mld_bank[i] <= wr_data;
            end
            led_pwm_select[8*i +: 8] <= pwm_bank[i];
            led_melody_select[8*i +: 8] <= mld_bank[i];
         end
      end
   end

   // Registered control outputs, so every change trails the register write by one cycle.
   always_ff @(posedge clk) begin
      if (cfg_clr) begin
         osc_run <= 1'b0;
         ghost_suppress_enable <= 1'b0;
         clock_mode <= '0;
         max_current_code <= RST_MATRIX[3:1];
         matrix_enable <= 1'b0;
         column_group_melody_bit <= '0;
         threshold_select <= RST_THRESHOLD;
         auto_threshold <= 1'b1;
      end else begin
         osc_run <= osc_en | matrix[BIT_MTX_EN];
         ghost_suppress_enable <= option[BIT_GHOST];
         clock_mode <= '{ext_clock: ext_sel, clock_out: out_sel, melody: mel_sel};
         max_current_code <= matrix[3:BIT_MAX_CURRENT_CODE_LO];
         matrix_enable <= matrix[BIT_MTX_EN];
         column_group_melody_bit <= group;
         threshold_select <= threshold;
         auto_threshold <= (threshold == 8'h00);
      end
   end

   // Group sequencer: each rising melody input edge lights the next row, from row I down to A.
   // It only steps while melody mode wins the clock priority and a group is chosen.
   always_ff @(posedge clk) begin
      if (cfg_clr) begin
         row_step <= ROW_FIRST;
         group_row_lit <= 9'h000;
      end else begin
         if (mel_sel && group != '0 && mel_edge) begin
            row_step <= (row_step == 4'h0) ? ROW_FIRST : row_step - 4'h1;
         end
         group_row_lit <= (mel_sel && group != '0) ? 9'(9'h001 << row_step) : 9'h000;
      end
   end

   // Checks on the register behaviour.
   property p_memclr;
      @(posedge clk) disable iff (soft_reset_bit)
      wr_stb && ptr == REG_RESET && wr_data[1] |=> memory_clear_pulse ##1 !memory_clear_pulse;
   endproperty
   a_memclr: assert property (p_memclr) else $error("Memory clear pulse wrong.");
   property p_soft_reset_bit;
      @(posedge clk) disable iff (soft_reset_bit)
      wr_stb && ptr == REG_RESET && wr_data[0] |=> soft_reset_pulse ##2 !matrix_enable;
   endproperty
   a_soft_reset_bit: assert property (p_soft_reset_bit) else $error("Soft reset did not clear controls.");
   property p_selfclr;
      @(posedge clk) disable iff (soft_reset_bit)
      soft_reset_pulse |=> !soft_reset_pulse;
   endproperty
   a_selfclr: assert property (p_selfclr) else $error("Command bit stuck high.");
   property p_osc;
      @(posedge clk) disable iff (soft_reset_bit)
      wr_stb && ptr == REG_MATRIX && wr_data[0] && !soft_reset_pulse |-> ##2 osc_run;
   endproperty
   a_osc: assert property (p_osc) else $error("Oscillator off with matrix enabled.");
   property p_prio;
      @(posedge clk) disable iff (soft_reset_bit)
      clock_mode.ext_clock |-> !clock_mode.clock_out && !clock_mode.melody;
   endproperty
   a_prio: assert property (p_prio) else $error("Clock mode priority broken.");
   property p_ghost;
      @(posedge clk) disable iff (soft_reset_bit)
      wr_stb && ptr == REG_OPTION && !soft_reset_pulse |-> ##2
         ghost_suppress_enable == $past(wr_data[3], 2);
   endproperty
   a_ghost: assert property (p_ghost) else $error("Ghost suppression not updated.");
   property p_current;
      @(posedge clk) disable iff (soft_reset_bit)
      wr_stb && ptr == REG_MATRIX && !soft_reset_pulse |-> ##2
         max_current_code == $past(wr_data[3:1], 2);
   endproperty
   a_current: assert property (p_current) else $error("Current code not updated.");
   property p_unimp;
      @(posedge clk) disable iff (soft_reset_bit)
      ptr == REG_POWER |-> rd_data[7:1] == 7'h00;
   endproperty
   a_unimp: assert property (p_unimp) else $error("Unused bits read non-zero.");
   property p_thr;
      @(posedge clk) disable iff (soft_reset_bit)
      threshold == 8'h00 && !soft_reset_pulse |=> auto_threshold;
   endproperty
   a_thr: assert property (p_thr) else $error("Auto threshold not flagged.");
endmodule : lmx_control_regs

// ---- bench/lmx_host_model.sv ----
// Serial bus master model standing in for the host processor.
`timescale 1ns/1ps
module lmx_host_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl_drive,
   output logic sda_pull
);
   // Half a bit in clock cycles, kept well above the three-cycle synchroniser latency.
   localparam int HALF = 8;

   // The bus idles released, clock high.
   initial begin
      scl_drive = 1'b1;
      sda_pull = 1'b0;
   end

   // Waits one half bit; every pin change lands just after a falling edge.
   task automatic half();
      repeat (HALF) @(negedge clk);
   endtask : half

   // Start or repeated start: data falls while the clock is high.
   task automatic start();
      sda_pull = 1'b0;
      half();
      scl_drive = 1'b1;
      half();
      sda_pull = 1'b1;
      half();
      scl_drive = 1'b0;
   endtask : start

   // Stop: data rises while the clock is high, leaving the bus idle.
   task automatic stop();
      sda_pull = 1'b1;
      half();
      scl_drive = 1'b1;
      half();
      sda_pull = 1'b0;
      half();
   endtask : stop

   // One clock pulse; the line is sampled late in the high phase, where it has settled.
   task automatic pulse(output logic bit_seen);
      half();
      scl_drive = 1'b1;
      half();
      bit_seen = sda_line;
      scl_drive = 1'b0;
   endtask : pulse

   task automatic send(input logic [7:0] data, output logic acked);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         sda_pull = ~data[i];
         pulse(b);
      end
      sda_pull = 1'b0;
      pulse(b);
      acked = ~b;
   endtask : send

   // Receives one byte; the last byte is refused so that the device ends the read.
   task automatic recv(input logic last, output logic [7:0] data);
      logic b;
      sda_pull = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         pulse(b);
         data[i] = b;
      end
      // The acknowledge level stands until the next byte or the stop changes it.
      sda_pull = ~last;
      pulse(b);
   endtask : recv
endmodule : lmx_host_model

// ---- bench/tb_led_matrix_control_registers.sv ----
// Self-checking bench for the LED matrix control register bank.
`timescale 1ns/1ps
module tb_led_matrix_control_registers;
   import lmx_pkg::*;
   logic clk, soft_reset_bit, melody_in, scl, sda_pull, sda_line, sda_out, sda_oe_n;
   logic soft_reset_pulse, memory_clear_pulse, osc_run, ghost_suppress_enable, matrix_enable;
   logic [1:0] addr_sel;
   lmx_clock_mode_type clock_mode;
   logic [2:0] max_current_code;
   logic [8*BANK_REGS-1:0] led_pwm_select, led_melody_select;
   logic [GROUP_BITS-1:0] column_group_melody_bit;
   logic [8:0] group_row_lit;
   logic [7:0] threshold_select;
   logic auto_threshold;
   int mismatches, compares, soft_count, clear_count, row;
   // Expected read value at every pointer.
   logic [7:0] mdl [0:255];

   // The data wire has a pull-up; either party pulling it low wins.
   assign sda_line = (sda_pull || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;

   lmx_control_regs i_dut (.clk(clk), .soft_reset_bit(soft_reset_bit), .scl_in(scl), .sda_in(sda_line),
      .addr_sel(addr_sel), .melody_in(melody_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
      .soft_reset_pulse(soft_reset_pulse), .memory_clear_pulse(memory_clear_pulse),
      .osc_run(osc_run), .ghost_suppress_enable(ghost_suppress_enable),
      .clock_mode(clock_mode), .max_current_code(max_current_code),
      .matrix_enable(matrix_enable), .led_pwm_select(led_pwm_select),
      .led_melody_select(led_melody_select),
      .column_group_melody_bit(column_group_melody_bit), .group_row_lit(group_row_lit),
      .threshold_select(threshold_select), .auto_threshold(auto_threshold));

   lmx_host_model i_host (.clk(clk), .sda_line(sda_line), .scl_drive(scl),
      .sda_pull(sda_pull));

   // Free-running 200 MHz clock.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts command pulses; each write of a command bit must give exactly one high cycle.
   // Sampled on the falling edge, where the registered pulse has settled.
   always @(negedge clk) begin
      if (!soft_reset_bit && soft_reset_pulse) soft_count++;
      if (!soft_reset_bit && memory_clear_pulse) clear_count++;
   end

   // Compares one value and reports a difference at once.
   task automatic check(input string name, input logic [87:0] seen, input logic [87:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // Model reset: every register back to its default.
   function automatic void mdl_reset();
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[5] = 8'h1e;
   endfunction : mdl_reset

   // Applies one written byte; unimplemented bits and places stay zero, except matrix bit 4, which stays one.
   function automatic void mdl_write(input int a, input int d);
      if (a == 2) mdl[a] = 8'(d & 1);
      else if (a == 4 || a == 'h2a) mdl[a] = 8'(d & 'h0f);
      else if (a == 5) mdl[a] = 8'('h10 | (d & 'h0f));
      else if ((a >= 6 && a <= 'h1b) || a == 'h2b) mdl[a] = 8'(d);
   endfunction : mdl_write

   // Burst write from a pointer; hit low sends a foreign slave address.
   task automatic wr(input int a, input int d[$], input logic hit = 1'b1);
      logic ack;
      i_host.start();
      i_host.send({SLAVE_ADDR_BASE, hit ? addr_sel : ~addr_sel, 1'b0}, ack);
      check("address_ack", ack, hit);
      if (hit) begin
         i_host.send(8'(a), ack);
         foreach (d[i]) begin
            i_host.send(8'(d[i]), ack);
            mdl_write(a + i, d[i]);
         end
      end
      i_host.stop();
   endtask : wr

   // Burst read from a pointer, each byte compared with the model.
   task automatic rd(input int a, input int n);
      logic ack;
      logic [7:0] b;
      i_host.start();
      i_host.send({SLAVE_ADDR_BASE, addr_sel, 1'b0}, ack);
      i_host.send(8'(a), ack);
      i_host.start();
      i_host.send({SLAVE_ADDR_BASE, addr_sel, 1'b1}, ack);
      for (int i = 0; i < n; i++) begin
         i_host.recv(i == n - 1, b);
         check("read_data", b, mdl[a + i]);
      end
      i_host.stop();
   endtask : rd

   // Compares every control output but group_row_lit and the command pulses with what the model's registers imply.
   task automatic check_outputs();
      logic [87:0] pwm, mld;
      logic [7:0] o;
      o = mdl[4];
      for (int k = 0; k < BANK_REGS; k++) begin
         pwm[8*k +: 8] = mdl[6 + k];
         mld[8*k +: 8] = mdl['h11 + k];
      end
      check("osc_run", osc_run, mdl[2][0] | mdl[5][0]);
      check("matrix_enable", matrix_enable, mdl[5][0]);
      check("max_current_code", max_current_code, mdl[5][3:1]);
      check("ghost", ghost_suppress_enable, o[3]);
      check("clock_mode", clock_mode, {o[0], o[1] & ~o[0], o[2] & ~o[1] & ~o[0]});
      check("pwm", led_pwm_select, pwm);
      check("melody", led_melody_select, mld);
      check("group", column_group_melody_bit, mdl['h2a][3:0]);
      check("threshold", threshold_select, mdl['h2b]);
      check("auto_threshold", auto_threshold, mdl['h2b] == 8'h00);
   endtask : check_outputs

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : summarize

   // Watchdog: a hung sequence is cut short and counted as a failure.
   initial begin
      repeat (99000) @(posedge clk);
      mismatches++;
      summarize();
   end

   // Main sequence.
   initial begin
      int q[$];
      int g;
      void'($urandom(51));
      soft_reset_bit = 1'b1;
      melody_in = 1'b0;
      addr_sel = 2'($urandom);
      mismatches = 0;
      compares = 0;
      soft_count = 0;
      clear_count = 0;
      mdl_reset();
      repeat (10) @(negedge clk);
      soft_reset_bit = 1'b0;
      repeat (5) @(negedge clk);
      // Defaults after reset, including the unmapped place 0x03.
      check("sda_oe_n", sda_oe_n, 1'b1);
      check_outputs();
      rd(1, 6);
      rd('h11, 1);
      rd('h2a, 2);
      // Every option combination, with junk in the unimplemented upper bits.
      for (int v = 0; v < 16; v++) begin
         wr(4, '{($urandom & 'hf0) | v});
         check_outputs();
         rd(4, 1);
      end
      // Oscillator follows either its own enable or the matrix enable.
      for (int c = 0; c < 4; c++) begin
         wr(2, '{($urandom & 'hfe) | (c & 1)});
         wr(5, '{($urandom & 'hfe) | (c >> 1)});
         check_outputs();
         rd(2, 4);
      end
      // Both banks in one burst running on into unmapped 0x1c.
      for (int i = 0; i < 23; i++) q.push_back($urandom & 'hff);
      wr(6, q);
      check_outputs();
      rd(6, 23);
      // A foreign slave address is not acknowledged and changes nothing.
      wr(5, '{'h00}, 1'b0);
      check_outputs();
      // Group sequence: one row lit, I down to A, wrapping.
      g = ($urandom % 15) + 1;
      wr('h2a, '{'hf0 | g});
      wr(4, '{4});
      row = 8;
      for (int p = 0; p < 11; p++) begin
         check("group_row_lit", group_row_lit, 9'h001 << row);
         melody_in = 1'b1;
         repeat (6) @(negedge clk);
         melody_in = 1'b0;
         repeat (6) @(negedge clk);
         row = (row == 0) ? 8 : row - 1;
      end
      wr(4, '{5});
      check("group_row_lit", group_row_lit, 9'h000);
      // Fixed threshold, then back to automatic detection.
      wr('h2b, '{1 << ($urandom % 8)});
      check_outputs();
      wr('h2b, '{0});
      check_outputs();
      // Memory clear: one pulse, registers untouched, command reads back zero.
      wr(1, '{2});
      check("clear_count", clear_count, 1);
      check("soft_count", soft_count, 0);
      check_outputs();
      rd(1, 1);
      // Soft reset: one pulse, then all registers at their defaults.
      wr(1, '{1});
      mdl_reset();
      repeat (4) @(negedge clk);
      check("soft_count", soft_count, 1);
      check_outputs();
      rd(1, 5);
      summarize();
   end
endmodule : tb_led_matrix_control_registers
